//--- hdl/dcs_ddr2_state.sv
// DDR2 device command decode, clock enable state machine and register slave
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module dcs_ddr2_state
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [dcs_pkg::APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Memory pins from the controller
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [dcs_pkg::BANK_W-1:0] ba,
    input wire logic [dcs_pkg::ADDR_W-1:0] addr,
    input wire logic odt,
    input wire logic dm,
    // Array side results
    output logic wr_beat_write,
    output logic wr_beat_masked,
    output logic rd_beat,
    output logic termination_on
);
    import dcs_pkg::*;

    localparam int PIN_W = 8 + BANK_W + ADDR_W;

    // Pin synchronisers; all pins are foreign to pclk
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    logic ck_d;
    wire [PIN_W-1:0] pin_raw = {ck, cke, cs_n, ras_n, cas_n, we_n, odt, dm, ba, addr};
    wire ck_s = pin_sync[PIN_W-1];
    wire cke_s = pin_sync[PIN_W-2];
    wire odt_s = pin_sync[PIN_W-7];
    wire dm_s = pin_sync[PIN_W-8];
    wire [BANK_W-1:0] ba_s = pin_sync[ADDR_W+BANK_W-1:ADDR_W];
    wire [ADDR_W-1:0] addr_s = pin_sync[ADDR_W-1:0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
            ck_d <= 1'b0;
        end
        else
        begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            ck_d <= ck_s;
        end
    end

    // Commands only count at input clock rise; beats at either edge
    wire cmd_edge = ck_s & ~ck_d;
    wire beat_edge = ck_s ^ ck_d;

    dcs_cmd_t cmd;

    dcs_cmd_decode u_decode
    (
        .cs_n(pin_sync[PIN_W-3]),
        .ras_n(pin_sync[PIN_W-4]),
        .cas_n(pin_sync[PIN_W-5]),
        .we_n(pin_sync[PIN_W-6]),
        .cmd(cmd)
    );

    // Core state
    dcs_state_t state;
    dcs_state_t next_state;
    logic [NUM_BANKS-1:0] banks;
    logic [NUM_BANKS-1:0] next_banks;
    logic cke_prev;
    logic [2:0] beat_cnt;
    logic burst_ap;
    logic [BANK_W-1:0] burst_bank;
    logic next_burst_ap;
    logic [BANK_W-1:0] next_burst_bank;
    logic start_burst;
    logic illegal_evt;
    logic bl8;
    logic rtt_en;
    logic odt_allow;
    logic illegal;
    logic [7:0] sr_wait;

    wire [NUM_BANKS-1:0] bank_bit = NUM_BANKS'(1) << ba_s;
    wire [NUM_BANKS-1:0] burst_bit = NUM_BANKS'(1) << burst_bank;
    wire bank_open = |(banks & bank_bit);
    wire ap_flag = addr_s[AUTO_PRECHARGE_BIT];
    wire nop_like = (cmd == CMD_NOP) || (cmd == CMD_DESELECT);
    wire cke_fall = cke_prev & ~cke_s;
    wire cke_rise = ~cke_prev & cke_s;
    wire cke_high = cke_prev & cke_s;
    wire sr_busy = |sr_wait;
    wire in_burst = (state == ST_READ) || (state == ST_WRITE);
    wire burst_done = in_burst && beat_edge && (beat_cnt == (bl8 ? BURST8_LAST : BURST4_LAST));
    wire same_cmd = (state == ST_READ) ? (cmd == CMD_READ) : (cmd == CMD_WRITE);
    // A burst with auto-precharge closes its bank on completion
    wire [NUM_BANKS-1:0] end_banks = burst_ap ? (banks & ~burst_bit) : banks;
    wire dcs_state_t end_state = (|end_banks) ? ST_ACTIVE : ST_IDLE;
    wire [NUM_BANKS-1:0] pre_banks = ap_flag ? '0 : (banks & ~bank_bit);

    always_comb
    begin
        next_state = state;
        next_banks = banks;
        next_burst_ap = burst_ap;
        next_burst_bank = burst_bank;
        start_burst = 1'b0;
        illegal_evt = 1'b0;
        if (!cmd_edge)
        begin
            // Exit needs only the enable level, not an input clock edge
            if (state == ST_SELF_REFRESH && cke_s)
                next_state = ST_IDLE;
            else if (burst_done)
            begin
                next_state = end_state;
                next_banks = end_banks;
            end
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if (cke_fall)
                    begin
                        if (nop_like)
                            next_state = ST_PD_PRECHARGE;
                        else if (cmd == CMD_REFRESH)
                            next_state = ST_SELF_REFRESH;
                        else
                            illegal_evt = 1'b1;
                    end
                    else if (!cke_prev)
                        illegal_evt = !cke_rise || !nop_like;
                    else if (cmd == CMD_ACTIVATE)
                    begin
                        next_banks = banks | bank_bit;
                        next_state = ST_ACTIVE;
                    end
                    else if (cmd == CMD_READ || cmd == CMD_WRITE)
                        illegal_evt = 1'b1;
                end
                ST_ACTIVE:
                begin
                    if (cke_fall)
                    begin
                        if (nop_like)
                            next_state = ST_PD_ACTIVE;
                        else
                            illegal_evt = 1'b1;
                    end
                    else if (!cke_prev)
                        illegal_evt = !cke_rise || !nop_like;
                    else if (cmd == CMD_READ || cmd == CMD_WRITE)
                    begin
                        if (!bank_open || (cmd == CMD_READ && sr_busy))
                            illegal_evt = 1'b1;
                        else
                        begin
                            next_state = (cmd == CMD_READ) ? ST_READ : ST_WRITE;
                            start_burst = 1'b1;
                            next_burst_ap = ap_flag;
                            next_burst_bank = ba_s;
                        end
                    end
                    else if (cmd == CMD_ACTIVATE)
                    begin
                        if (bank_open)
                            illegal_evt = 1'b1;
                        else
                            next_banks = banks | bank_bit;
                    end
                    else if (cmd == CMD_PRECHARGE)
                    begin
                        next_banks = pre_banks;
                        next_state = (|pre_banks) ? ST_ACTIVE : ST_IDLE;
                    end
                    else if (!nop_like)
                        illegal_evt = 1'b1;
                end
                ST_READ, ST_WRITE:
                begin
                    // Short bursts cannot be cut, long ones restart
                    if (same_cmd && cke_high && bl8 && bank_open)
                    begin
                        start_burst = 1'b1;
                        next_burst_ap = ap_flag;
                        next_burst_bank = ba_s;
                    end
                    else
                    begin
                        illegal_evt = !nop_like || !cke_high;
                        if (burst_done)
                        begin
                            next_state = end_state;
                            next_banks = end_banks;
                        end
                    end
                end
                ST_PD_PRECHARGE, ST_PD_ACTIVE:
                begin
                    if (cke_s)
                    begin
                        next_state = (state == ST_PD_ACTIVE) ? ST_ACTIVE : ST_IDLE;
                        illegal_evt = !nop_like;
                    end
                end
                ST_SELF_REFRESH:
                begin
                    if (cke_s)
                        next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
            banks <= '0;
            burst_ap <= 1'b0;
            burst_bank <= '0;
            cke_prev <= 1'b0;
        end
        else
        begin
            state <= next_state;
            banks <= next_banks;
            burst_ap <= next_burst_ap;
            burst_bank <= next_burst_bank;
            if (cmd_edge)
                cke_prev <= cke_s;
        end
    end

    // Beat counter restarts on every accepted burst command
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            beat_cnt <= '0;
        else if (start_burst)
            beat_cnt <= '0;
        else if (in_burst && beat_edge)
            beat_cnt <= beat_cnt + 3'h1;
    end

    // Read lockout after self refresh exit, counted in input clocks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sr_wait <= '0;
        else if (state == ST_SELF_REFRESH && next_state == ST_IDLE)
            sr_wait <= SELF_REFRESH_EXIT_READ_DELAY;
        else if (cmd_edge && sr_busy)
            sr_wait <= sr_wait - 8'h01;
    end

    // Mode register capture
    wire mode_set = cmd_edge && state == ST_IDLE && cke_high && cmd == CMD_MODE_SET;
    wire [2:0] bl_code = addr_s[BL_FIELD_MSB:0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bl8 <= 1'b0;
            rtt_en <= 1'b0;
        end
        else if (mode_set && ba_s == MR_SEL_MODE && (bl_code == BL_CODE_4 || bl_code == BL_CODE_8))
            bl8 <= (bl_code == BL_CODE_8);
        else if (mode_set && ba_s == MR_SEL_EMR1)
            rtt_en <= addr_s[EMR1_RTT_LO_BIT] | addr_s[EMR1_RTT_HI_BIT];
    end

    // Data path strobes; mask is taken with its own beat
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_beat_write <= 1'b0;
            wr_beat_masked <= 1'b0;
            rd_beat <= 1'b0;
            termination_on <= 1'b0;
        end
        else
        begin
            wr_beat_write <= state == ST_WRITE && beat_edge && !start_burst && !dm_s;
            wr_beat_masked <= state == ST_WRITE && beat_edge && !start_burst && dm_s;
            rd_beat <= state == ST_READ && beat_edge && !start_burst;
            termination_on <= odt_s && rtt_en && odt_allow && state != ST_SELF_REFRESH;
        end
    end

    // APB slave, zero wait states
    wire sel_ctrl = paddr == REG_CTRL;
    wire sel_status = paddr == REG_STATUS;
    wire sel_mode = paddr == REG_MODE;
    wire mapped = sel_ctrl | sel_status | sel_mode;
    wire wr_en = psel & penable & pwrite;
    wire illegal_clr = wr_en & sel_status & pwdata[STATUS_ILLEGAL_BIT];
    wire [31:0] ctrl_word = {31'h0, odt_allow};
    wire [31:0] status_word = {15'h0, bl8, banks, 2'h0, sr_busy, illegal, 1'h0, state};
    wire [31:0] mode_word = {30'h0, rtt_en, bl8};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_word : sel_status ? status_word : sel_mode ? mode_word : 32'h0;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            odt_allow <= CTRL_ODT_ALLOW_RESET;
            illegal <= 1'b0;
        end
        else
        begin
            if (psel && !penable && !pwrite)
                prdata <= rd_mux;
            if (wr_en && sel_ctrl)
                odt_allow <= pwdata[CTRL_ODT_ALLOW_BIT];
            // A new event wins over a clear in the same cycle
            illegal <= illegal_evt | (illegal & ~illegal_clr);
        end
    end

endmodule

//--- hdl/dcs_pkg.sv
// Shared constants and types for the DDR2 command and state logic
package dcs_pkg;

    // APB register map
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] REG_MODE = 8'h08;

    // Register fields and reset values
    localparam int CTRL_ODT_ALLOW_BIT = 0;
    localparam logic CTRL_ODT_ALLOW_RESET = 1'b1;
    localparam int STATUS_ILLEGAL_BIT = 4;

    // Pin bus widths and bank count
    localparam int BANK_W = 3;
    localparam int NUM_BANKS = 8;
    localparam int ADDR_W = 14;

    // Address bit meanings
    localparam int AUTO_PRECHARGE_BIT = 10;
    localparam int EMR1_RTT_LO_BIT = 2;
    localparam int EMR1_RTT_HI_BIT = 6;
    localparam int BL_FIELD_MSB = 2;

    // Mode register selection and burst length codes
    localparam logic [BANK_W-1:0] MR_SEL_MODE = 3'h0;
    localparam logic [BANK_W-1:0] MR_SEL_EMR1 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;

    // Last beat index of a burst, both clock edges counted
    localparam logic [2:0] BURST4_LAST = 3'h3;
    localparam logic [2:0] BURST8_LAST = 3'h7;

    // Self refresh exit read delay, in input clocks
    localparam logic [7:0] SELF_REFRESH_EXIT_READ_DELAY = 8'hc8;

    typedef enum logic [2:0]
    {
        CMD_DESELECT,
        CMD_NOP,
        CMD_READ,
        CMD_WRITE,
        CMD_ACTIVATE,
        CMD_PRECHARGE,
        CMD_REFRESH,
        CMD_MODE_SET
    } dcs_cmd_t;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_ACTIVE,
        ST_READ,
        ST_WRITE,
        ST_PD_PRECHARGE,
        ST_PD_ACTIVE,
        ST_SELF_REFRESH
    } dcs_state_t;

endpackage

//--- hdl/dcs_cmd_decode.sv
// Command decoder for the chip select and strobe pins
`timescale 1ns/10ps
module dcs_cmd_decode
(
    // Sampled control pins
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    // Decoded command
    output dcs_pkg::dcs_cmd_t cmd
);
    import dcs_pkg::*;

    wire [2:0] strobes = {ras_n, cas_n, we_n};

    assign cmd = cs_n ? CMD_DESELECT :
        (strobes == 3'h7) ? CMD_NOP :
        (strobes == 3'h5) ? CMD_READ :
        (strobes == 3'h4) ? CMD_WRITE :
        (strobes == 3'h3) ? CMD_ACTIVATE :
        (strobes == 3'h2) ? CMD_PRECHARGE :
        (strobes == 3'h1) ? CMD_REFRESH : CMD_MODE_SET;

endmodule

//--- bench/dcs_ddr2_state_checker.sv
// Port assertions for the DDR2 command and state logic
`timescale 1ns/10ps
module dcs_ddr2_state_checker
import dcs_pkg::*;
(
    // Watched ports
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic odt,
    input wire logic dm,
    input wire logic wr_beat_write,
    input wire logic wr_beat_masked,
    input wire logic rd_beat,
    input wire logic termination_on
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    ready_always_a: assert property (pready)
        else $error("pready low");
    err_in_access_a: assert property (pslverr |-> acc)
        else $error("pslverr outside access");
    err_zero_data_a: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("data on refused read");
    mapped_ok_a: assert property (acc && (paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_MODE) |-> !pslverr)
        else $error("mapped access refused");
    beat_excl_a: assert property (!(wr_beat_write && wr_beat_masked))
        else $error("beat both stored and masked");
    write_pulse_a: assert property (wr_beat_write |=> !wr_beat_write)
        else $error("stored beat pulse too long");
    mask_blocks_a: assert property (wr_beat_masked |-> $past(dm, 3))
        else $error("beat masked with mask low");
    mask_passes_a: assert property (wr_beat_write |-> !$past(dm, 3))
        else $error("beat stored with mask high");
    odt_off_a: assert property (!odt [*6] |-> !termination_on)
        else $error("termination without request");
    dir_excl_a: assert property (rd_beat |-> !(wr_beat_write || wr_beat_masked))
        else $error("read and write beats together");
    read_pulse_a: assert property (rd_beat |=> !rd_beat)
        else $error("read beat pulse too long");
    cover property (wr_beat_masked);
    cover property (rd_beat);
    cover property (termination_on);
endmodule
bind dcs_ddr2_state dcs_ddr2_state_checker checker_inst
(
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .odt(odt), .dm(dm), .wr_beat_write(wr_beat_write),
    .wr_beat_masked(wr_beat_masked), .rd_beat(rd_beat), .termination_on(termination_on)
);

//--- bench/dcs_ctrl_model.sv
// Memory controller model driving clock, clock enable, commands and mask
`timescale 1ns/10ps
module dcs_ctrl_model
(
    // System clock
    input wire logic pclk,
    // Memory pins
    output logic ck,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [dcs_pkg::BANK_W-1:0] ba,
    output logic [dcs_pkg::ADDR_W-1:0] addr,
    output logic odt,
    output logic dm
);
    // Eight pclk per ck high half and thirteen per low half between cycles, well above the three the synchronisers need
    localparam int HALF = 8;
    initial
    begin
        ck = 1'b0;
        cke = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = 3'h0;
        addr = 14'h0;
        odt = 1'b0;
        dm = 1'b0;
    end
    // One ck period; mask moved mid-high so each beat sees its own level
    task automatic cyc(input logic ke, input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
        input logic dr, input logic df);
        @(posedge pclk);
        cke <= ke;
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        dm <= dr;
        repeat (HALF) @(posedge pclk);
        ck <= 1'b1;
        repeat (HALF / 2) @(posedge pclk);
        dm <= df;
        repeat (HALF / 2) @(posedge pclk);
        ck <= 1'b0;
        addr <= ~a;
        repeat (HALF / 2) @(posedge pclk);
    endtask
    // Clock enable and termination moved with ck standing still
    task automatic pins(input logic ke, input logic ot);
        @(posedge pclk);
        cke <= ke;
        odt <= ot;
        repeat (HALF) @(posedge pclk);
    endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the DDR2 command and state logic
`timescale 1ns/10ps
module tb_top;
    import dcs_pkg::*;
    localparam logic [3:0] NOP = 4'h7, RD = 4'h5, WR = 4'h4, ACT = 4'h3, PRE = 4'h2, REF = 4'h1, MRS = 4'h0;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ck, cke, cs_n, ras_n, cas_n, we_n, odt, dm;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic wr_beat_write, wr_beat_masked, rd_beat, termination_on;
    int num_errors = 0;
    int comparisons = 0;
    int n_wr = 0, n_mk = 0, n_rd = 0;
    dcs_ddr2_state dcs_ddr2_state_inst
    (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ck(ck), .cke(cke),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .dm(dm),
        .wr_beat_write(wr_beat_write), .wr_beat_masked(wr_beat_masked), .rd_beat(rd_beat),
        .termination_on(termination_on)
    );
    dcs_ctrl_model ctrl_model
    (
        .pclk(pclk), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .ba(ba), .addr(addr), .odt(odt), .dm(dm)
    );
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (wr_beat_write === 1'b1) n_wr <= n_wr + 1;
        if (wr_beat_masked === 1'b1) n_mk <= n_mk + 1;
        if (rd_beat === 1'b1) n_rd <= n_rd + 1;
    end
    task automatic tally_and_finish();
        if (num_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // Setup, then access held until pready is seen high
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; pready !== 1'b1 && n < 50; n++)
            @(posedge pclk);
        chk({31'h0, pready}, 32'h1, "apb wait");
        if (n >= 50)
            tally_and_finish();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic status(input logic [31:0] exp, input string m);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd & 32'h0001_ff37, exp, m);
    endtask
    task automatic t_regs();
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd & 32'h1, {31'h0, CTRL_ODT_ALLOW_RESET}, "ctrl reset");
        status(32'h0, "status reset");
        apb(1'b0, REG_MODE, 32'h0);
        chk(rd & 32'h3, 32'h0, "mode reset");
        apb(1'b1, 8'h0c, 32'hffff_ffff);
        chk({31'h0, err}, 32'h1, "unmapped write");
        apb(1'b0, 8'h0c, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped read");
        chk(rd, 32'h0, "unmapped data");
        apb(1'b1, REG_MODE, 32'h3);
        apb(1'b0, REG_MODE, 32'h0);
        chk(rd & 32'h3, 32'h0, "mode read-only");
    endtask
    task automatic t_idle();
        ctrl_model.cyc(1'b1, NOP, 3'h0, 14'h0, 1'b0, 1'b0);
        ctrl_model.cyc(1'b1, RD, 3'h3, 14'h0, 1'b0, 1'b0);
        status(32'h10, "read in idle");
        apb(1'b1, REG_STATUS, 32'h10);
        status(32'h0, "illegal clear");
    endtask
    // Second write at the next rise must not cut the four-beat burst
    task automatic t_write();
        int w0, m0;
        ctrl_model.cyc(1'b1, ACT, 3'h3, 14'h0, 1'b0, 1'b0);
        status(32'h0801, "bank open");
        w0 = n_wr;
        m0 = n_mk;
        ctrl_model.cyc(1'b1, WR, 3'h3, 14'h0, 1'b0, 1'b0);
        ctrl_model.cyc(1'b1, WR, 3'h3, 14'h0, 1'b1, 1'b1);
        ctrl_model.cyc(1'b1, NOP, 3'h0, 14'h0, 1'b0, 1'b0);
        chk(n_wr - w0, 32'h2, "stored beats");
        chk(n_mk - m0, 32'h2, "masked beats");
        status(32'h0811, "write interrupt");
        apb(1'b1, REG_STATUS, 32'h10);
    endtask
    task automatic t_read();
        int r0;
        r0 = n_rd;
        ctrl_model.cyc(1'b1, RD, 3'h3, 14'h0, 1'b0, 1'b0);
        ctrl_model.cyc(1'b1, NOP, 3'h0, 14'h0, 1'b0, 1'b0);
        ctrl_model.cyc(1'b1, 4'hf, 3'h0, 14'h0, 1'b0, 1'b0);
        chk(n_rd - r0, 32'h4, "read beats");
        status(32'h0801, "read done");
    endtask
    task automatic t_power_down();
        ctrl_model.cyc(1'b0, NOP, 3'h0, 14'h0, 1'b0, 1'b0);
        status(32'h0805, "active power-down");
        ctrl_model.cyc(1'b0, PRE, 3'h3, 14'h0, 1'b0, 1'b0);
        ctrl_model.cyc(1'b0, NOP, 3'h0, 14'h0, 1'b0, 1'b0);
        ctrl_model.cyc(1'b1, NOP, 3'h0, 14'h0, 1'b0, 1'b0);
        status(32'h0801, "power-down exit");
        ctrl_model.cyc(1'b1, NOP, 3'h0, 14'h0, 1'b0, 1'b0);
        ctrl_model.cyc(1'b1, PRE, 3'h5, 14'h0400, 1'b0, 1'b0);
        status(32'h0, "all banks closed");
        ctrl_model.cyc(1'b1, NOP, 3'h0, 14'h0, 1'b0, 1'b0);
        ctrl_model.cyc(1'b0, 4'hf, 3'h0, 14'h0, 1'b0, 1'b0);
        status(32'h4, "precharge power-down");
        ctrl_model.cyc(1'b0, NOP, 3'h0, 14'h0, 1'b0, 1'b0);
        ctrl_model.cyc(1'b0, NOP, 3'h0, 14'h0, 1'b0, 1'b0);
        ctrl_model.cyc(1'b1, 4'hf, 3'h0, 14'h0, 1'b0, 1'b0);
        status(32'h0, "idle again");
    endtask
    task automatic t_self_refresh();
        int w0;
        ctrl_model.cyc(1'b1, MRS, MR_SEL_MODE, {11'h0, BL_CODE_8}, 1'b0, 1'b0);
        ctrl_model.cyc(1'b1, MRS, MR_SEL_EMR1, 14'h0004, 1'b0, 1'b0);
        apb(1'b0, REG_MODE, 32'h0);
        chk(rd & 32'h3, 32'h3, "mode registers");
        ctrl_model.pins(1'b1, 1'b1);
        chk({31'h0, termination_on}, 32'h1, "termination on");
        apb(1'b1, REG_CTRL, 32'h0);
        ctrl_model.pins(1'b1, 1'b1);
        chk({31'h0, termination_on}, 32'h0, "termination blocked");
        apb(1'b1, REG_CTRL, 32'h1);
        ctrl_model.pins(1'b1, 1'b1);
        ctrl_model.cyc(1'b1, NOP, 3'h0, 14'h0, 1'b0, 1'b0);
        ctrl_model.cyc(1'b0, REF, 3'h0, 14'h0, 1'b0, 1'b0);
        status(32'h0001_0006, "self refresh");
        chk({31'h0, termination_on}, 32'h0, "termination off");
        ctrl_model.pins(1'b1, 1'b1);
        status(32'h0001_0020, "clockless exit");
        ctrl_model.cyc(1'b1, NOP, 3'h0, 14'h0, 1'b0, 1'b0);
        status(32'h0001_0020, "read lockout");
        w0 = n_wr;
        ctrl_model.cyc(1'b1, ACT, 3'h1, 14'h0, 1'b0, 1'b0);
        ctrl_model.cyc(1'b1, WR, 3'h1, 14'h0, 1'b0, 1'b0);
        repeat (4) ctrl_model.cyc(1'b1, NOP, 3'h0, 14'h0, 1'b0, 1'b0);
        chk(n_wr - w0, 32'h8, "long burst beats");
        status(32'h0001_0221, "long burst done");
    endtask
    initial
    begin
        #2000000;
        chk(32'h0, 32'h1, "run timeout");
        tally_and_finish();
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_idle();
        t_write();
        t_read();
        t_power_down();
        t_self_refresh();
        tally_and_finish();
    end
endmodule
